// [core/scpr_defs.svh]
// constants for the serial configuration memory readout block
// Function
// - count config clock rises when selected, enabled, released
// - low reset pin resets counter to zero, floats data
// - reset pin open-drain, pulled low during internal reset
// - chip enable high: standby, counter reset, float
// - load trigger instruction pulses config output low
// - cascade output low only past terminal count
// - cascade output high on reset low or disable
// - programming mode floats serial data output
// - test mode select sampled on test clock rise
// - test data in shifts into selected register
// - selected register shifts out on test data out
`ifndef SCPR_DEFS_SVH
`define SCPR_DEFS_SVH
// ***********************
// sizes
// ***********************
`define SCPR_DEPTH 1024
`define SCPR_IR_W 8
`define SCPR_ID_W 32
// ***********************
// instruction codes
// ***********************
`define SCPR_IR_CAPTURE 8'h01
`define SCPR_OP_BYPASS 8'hFF
`define SCPR_OP_IDCODE 8'hFE
`define SCPR_OP_LOAD_TRIG 8'hEE
`define SCPR_OP_ISP_ENTER 8'hE8
`define SCPR_OP_ISP_WRITE 8'hEA
`define SCPR_OP_ISP_LEAVE 8'hF0
// arbitrary identification value
`define SCPR_IDCODE_VAL 32'h0A5A_5001
// ***********************
// timing
// ***********************
`define SCPR_CLK_NS 40
`define SCPR_CFG_PULSE_NS 1000
`define SCPR_INT_RST_NS 2000
`define SCPR_CFG_PULSE_CYC ((`SCPR_CFG_PULSE_NS + `SCPR_CLK_NS - 1) / `SCPR_CLK_NS)
`define SCPR_INT_RST_CYC ((`SCPR_INT_RST_NS + `SCPR_CLK_NS - 1) / `SCPR_CLK_NS)
`define SCPR_TIMER_W 8
`endif

// [core/scpr_pkg.sv]
// types of the serial configuration memory readout block
`include "scpr_defs.svh"
package scpr_pkg;
  typedef logic [`SCPR_IR_W-1:0] scpr_ir_t;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } scpr_tap_state_t;
endpackage : scpr_pkg

// [core/scpr_jtag_if.sv]
// events passed from the test access port to the readout core
`timescale 1ns/1ps
interface scpr_jtag_if;
  import scpr_pkg::*;
  scpr_ir_t instr;
  logic update_ir;
  logic shift_dr;
  logic tdi;
  logic tap_reset;
  modport tap (output instr, output update_ir, output shift_dr, output tdi,
    output tap_reset);
  modport core (input instr, input update_ir, input shift_dr, input tdi, input tap_reset);
endinterface : scpr_jtag_if

// [core/scpr_tap.sv]
// test access port: state machine, instruction, bypass and id registers
`timescale 1ns/1ps
`include "scpr_defs.svh"
module scpr_tap #(
  parameter logic [`SCPR_ID_W-1:0] IDCODE = `SCPR_IDCODE_VAL
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // to core
  scpr_jtag_if.tap jt
);
  import scpr_pkg::*;

  scpr_tap_state_t st_r, st_nxt;
  logic tck_prev_r;
  logic tck_rise, tck_fall;
  scpr_ir_t ir_r, ir_sh_r;
  logic [`SCPR_ID_W-1:0] dr_sh_r;
  logic tdo_r;
  logic shift_bit;
  logic upd_ir_r;

  assign tck_rise = tck & ~tck_prev_r;
  assign tck_fall = ~tck & tck_prev_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tck_prev_r <= 1'b0;
    end else begin
      tck_prev_r <= tck;
    end
  end

  // ***********************
  // state machine
  // ***********************
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      TAP_RESET: st_nxt = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: st_nxt = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: st_nxt = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: st_nxt = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: st_nxt = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: st_nxt = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: st_nxt = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: st_nxt = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: st_nxt = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: st_nxt = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: st_nxt = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: st_nxt = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: st_nxt = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: st_nxt = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: st_nxt = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: st_nxt = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= TAP_RESET;
    end else if (tck_rise) begin
      st_r <= st_nxt;
    end
  end

  // ***********************
  // shift registers
  // ***********************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ir_sh_r <= '0;
      ir_r <= `SCPR_OP_IDCODE;
      dr_sh_r <= '0;
    end else if (tck_rise) begin
      unique case (st_r)
        TAP_RESET: ir_r <= `SCPR_OP_IDCODE;
        TAP_CAP_IR: ir_sh_r <= `SCPR_IR_CAPTURE;
        TAP_SH_IR: ir_sh_r <= {tdi, ir_sh_r[`SCPR_IR_W-1:1]};
        TAP_UPD_IR: ir_r <= ir_sh_r;
        TAP_CAP_DR: dr_sh_r <= (ir_r == `SCPR_OP_IDCODE) ? IDCODE : '0;
        TAP_SH_DR: begin
          if (ir_r == `SCPR_OP_IDCODE) begin
            dr_sh_r <= {tdi, dr_sh_r[`SCPR_ID_W-1:1]};
          end else begin
            dr_sh_r[0] <= tdi;
          end
        end
        default: ;
      endcase
    end
  end

  // ***********************
  // test data out, changes on falling test clock
  // ***********************
  assign shift_bit = (st_r == TAP_SH_IR) ? ir_sh_r[0] : dr_sh_r[0];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tdo_r <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= shift_bit;
      tdo_oe <= (st_r == TAP_SH_IR) || (st_r == TAP_SH_DR);
    end
  end

  // update strobe one cycle late, so the core decodes the new instruction
  always_ff @(posedge core_clk) begin
    if (srst) begin
      upd_ir_r <= 1'b0;
    end else begin
      upd_ir_r <= tck_rise && (st_r == TAP_UPD_IR);
    end
  end

  assign tdo = tdo_r;
  assign jt.instr = ir_r;
  assign jt.update_ir = upd_ir_r;
  assign jt.shift_dr = tck_rise && (st_r == TAP_SH_DR);
  assign jt.tdi = tdi;
  assign jt.tap_reset = (st_r == TAP_RESET);
endmodule : scpr_tap

// [core/scpr_top.sv]
// serial configuration memory readout: counter, data, cascade, reset and load pulse
`timescale 1ns/1ps
`include "scpr_defs.svh"
module scpr_top #(
  parameter int DEPTH = `SCPR_DEPTH,
  parameter int TC_LIMIT = `SCPR_DEPTH - 1,
  parameter logic [`SCPR_ID_W-1:0] IDCODE = `SCPR_IDCODE_VAL
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // configuration side
  input wire logic config_clk,
  input wire logic config_clk_select,
  input wire logic chip_enable_n,
  input wire logic oe_reset_n_i,
  output logic oe_reset_n_o,
  output logic oe_reset_n_oe,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  output logic cascade_enable_out_n,
  output logic config_pulse_n_o,
  output logic config_pulse_n_oe,
  // status
  output logic in_system_programming_active,
  // test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe
);
  import scpr_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] TC_VAL = TC_LIMIT[AW:0];
  localparam int PULSE_INT = `SCPR_CFG_PULSE_CYC;
  localparam int RST_INT = `SCPR_INT_RST_CYC;
  localparam logic [`SCPR_TIMER_W-1:0] PULSE_CYC = PULSE_INT[`SCPR_TIMER_W-1:0];
  localparam logic [`SCPR_TIMER_W-1:0] RST_CYC = RST_INT[`SCPR_TIMER_W-1:0];

  scpr_jtag_if jt ();

  logic mem [DEPTH];
  logic [AW:0] cnt_r;
  logic [AW-1:0] isp_addr_r;
  logic cfg_prev_r;
  logic cfg_rise;
  logic data_r;
  logic isp_r;
  logic [`SCPR_TIMER_W-1:0] rst_tmr_r;
  logic [`SCPR_TIMER_W-1:0] pulse_tmr_r;
  logic int_rst;
  logic active;
  logic past_tc;

  // ***********************
  // test access port
  // ***********************
  scpr_tap #(
    .IDCODE(IDCODE)
  ) u_tap (
    .core_clk(core_clk),
    .srst(srst),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo),
    .tdo_oe(tdo_oe),
    .jt(jt.tap)
  );

  // ***********************
  // internal reset, drives reset pin low
  // ***********************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rst_tmr_r <= RST_CYC;
    end else if (rst_tmr_r != '0) begin
      rst_tmr_r <= rst_tmr_r - 1'b1;
    end
  end

  assign int_rst = (rst_tmr_r != '0);
  assign oe_reset_n_o = 1'b0;
  assign oe_reset_n_oe = int_rst;

  // ***********************
  // address counter
  // ***********************
  assign active = ~chip_enable_n & oe_reset_n_i & ~int_rst;
  assign cfg_rise = config_clk & ~cfg_prev_r;
  assign past_tc = (cnt_r > TC_VAL);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_prev_r <= 1'b0;
    end else begin
      cfg_prev_r <= config_clk;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || !active) begin
      cnt_r <= '0;
    end else if (cfg_rise && config_clk_select && !past_tc) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // ***********************
  // serial data
  // ***********************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_r <= 1'b0;
    end else begin
      data_r <= past_tc ? 1'b1 : mem[cnt_r[AW-1:0]];
    end
  end

  assign serial_data_out = data_r;
  assign serial_data_out_oe = active & ~isp_r;

  // ***********************
  // cascade enable
  // ***********************
  assign cascade_enable_out_n = ~(~chip_enable_n & oe_reset_n_i & past_tc);

  // ***********************
  // programming through the test port
  // ***********************
  always_ff @(posedge core_clk) begin
    if (srst || jt.tap_reset) begin
      isp_r <= 1'b0;
    end else if (jt.update_ir && jt.instr == `SCPR_OP_ISP_ENTER) begin
      isp_r <= 1'b1;
    end else if (jt.update_ir && jt.instr == `SCPR_OP_ISP_LEAVE) begin
      isp_r <= 1'b0;
    end
  end

  assign in_system_programming_active = isp_r;

  always_ff @(posedge core_clk) begin
    if (srst || (jt.update_ir && jt.instr == `SCPR_OP_ISP_WRITE)) begin
      isp_addr_r <= '0;
    end else if (isp_r && jt.shift_dr && jt.instr == `SCPR_OP_ISP_WRITE) begin
      isp_addr_r <= isp_addr_r + 1'b1;
    end
  end

  // storage array, written bit by bit while programming
  always_ff @(posedge core_clk) begin
    if (isp_r && jt.shift_dr && jt.instr == `SCPR_OP_ISP_WRITE) begin
      mem[isp_addr_r] <= jt.tdi;
    end
  end

  // ***********************
  // configuration pulse
  // ***********************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pulse_tmr_r <= '0;
    end else if (jt.update_ir && jt.instr == `SCPR_OP_LOAD_TRIG) begin
      pulse_tmr_r <= PULSE_CYC;
    end else if (pulse_tmr_r != '0) begin
      pulse_tmr_r <= pulse_tmr_r - 1'b1;
    end
  end

  assign config_pulse_n_o = 1'b0;
  assign config_pulse_n_oe = (pulse_tmr_r != '0);
endmodule : scpr_top

// [verification/scpr_monitor.sv]
// port checker of the readout block
`timescale 1ns/1ps
module scpr_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // configuration side
  input wire logic config_clk_select,
  input wire logic chip_enable_n,
  input wire logic oe_reset_n_i,
  input wire logic oe_reset_n_oe,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic cascade_enable_out_n,
  input wire logic config_pulse_n_oe,
  input wire logic in_system_programming_active
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_casc_low; !cascade_enable_out_n |-> !chip_enable_n && oe_reset_n_i; endproperty
  a_casc_low: assert property (p_casc_low) else $error("cascade low while off");
  property p_casc_off; $rose(chip_enable_n) || $fell(oe_reset_n_i) |-> cascade_enable_out_n;
  endproperty
  a_casc_off: assert property (p_casc_off) else $error("cascade not released");
  property p_float_rst; !oe_reset_n_i |-> !serial_data_out_oe; endproperty
  a_float_rst: assert property (p_float_rst) else $error("data driven in reset");
  property p_float_ce; chip_enable_n |-> !serial_data_out_oe; endproperty
  a_float_ce: assert property (p_float_ce) else $error("data driven in standby");
  property p_float_isp; in_system_programming_active |-> !serial_data_out_oe; endproperty
  a_float_isp: assert property (p_float_isp) else $error("data driven in programming");
  property p_pulse; $rose(config_pulse_n_oe) |-> ##24 config_pulse_n_oe ##1 !config_pulse_n_oe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("load pulse length wrong");
  property p_int_rst; $fell(srst) |-> ##47 oe_reset_n_oe ##[1:4] !oe_reset_n_oe; endproperty
  a_int_rst: assert property (p_int_rst) else $error("internal reset span wrong");
  property p_hold;
    !config_clk_select && !$past(config_clk_select) && !$past(config_clk_select, 2)
      && serial_data_out_oe && $past(serial_data_out_oe) |-> $stable(serial_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved while deselected");
endmodule : scpr_monitor

// [verification/scpr_fpga_model.sv]
// far-side configuration master: clock, bit capture, reset wire
`timescale 1ns/1ps
module scpr_fpga_model (
  // clock and control
  input wire logic core_clk,
  input wire logic run,
  input wire logic hold_low,
  // memory side
  input wire logic data,
  input wire logic data_oe,
  input wire logic rst_oe,
  input wire logic next_ce_n,
  output logic config_clk,
  output logic oe_wire,
  output logic next_sel,
  output logic [31:0] got,
  output logic [5:0] nbits
);
  logic [1:0] ph_r;
  // ****
  // wire and clock
  // ****
  assign oe_wire = !(rst_oe || hold_low); // pull-up wire
  assign next_sel = !next_ce_n;
  always @(posedge core_clk) begin
    ph_r <= run ? ph_r + 2'h1 : 2'h0;
    config_clk <= run && (ph_r[0] ^ ph_r[1]);
    if (!run) begin
      nbits <= 6'h00;
    end else if (ph_r == 2'h1) begin
      got[nbits[4:0]] <= data_oe ? data : ~data;
      nbits <= nbits + 6'h01;
    end
  end
endmodule : scpr_fpga_model

// [verification/scpr_top_test.sv]
// self-checking bench of the readout block
`timescale 1ns/1ps
`include "scpr_defs.svh"
bind scpr_top scpr_monitor u_mon (.core_clk(core_clk), .srst(srst),
  .config_clk_select(config_clk_select), .chip_enable_n(chip_enable_n),
  .oe_reset_n_i(oe_reset_n_i), .oe_reset_n_oe(oe_reset_n_oe),
  .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
  .cascade_enable_out_n(cascade_enable_out_n), .config_pulse_n_oe(config_pulse_n_oe),
  .in_system_programming_active(in_system_programming_active));
module scpr_top_test;
  localparam logic [31:0] ID_V = 32'h0C0F_FEE1; // arbitrary value
  localparam logic [15:0] PAT = 16'hC3A5;
  logic core_clk, srst, sel, ce_n, tck, tms, tdi, run, hold_low, cclk, oe_w;
  logic dout, dout_oe, rst_oe, casc, pulse_oe, isp, tdo, tdo_oe, nxt;
  logic [31:0] got, v;
  logic [5:0] nb;
  int err_count = 0, checked = 0, run_len = 0, last_len = 0;
  // ****
  // design and partner
  // ****
  scpr_top #(.DEPTH(16), .TC_LIMIT(15), .IDCODE(ID_V)) u_dut (.core_clk(core_clk),
    .srst(srst), .config_clk(cclk), .config_clk_select(sel), .chip_enable_n(ce_n),
    .oe_reset_n_i(oe_w), .oe_reset_n_o(), .oe_reset_n_oe(rst_oe), .serial_data_out(dout),
    .serial_data_out_oe(dout_oe), .cascade_enable_out_n(casc), .config_pulse_n_o(),
    .config_pulse_n_oe(pulse_oe), .in_system_programming_active(isp), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  scpr_fpga_model u_fpga (.core_clk(core_clk), .run(run), .hold_low(hold_low),
    .data(dout), .data_oe(dout_oe), .rst_oe(rst_oe), .next_ce_n(casc),
    .config_clk(cclk), .oe_wire(oe_w), .next_sel(nxt), .got(got), .nbits(nb));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (pulse_oe) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_len <= run_len;
      run_len <= 0;
    end
  end
  // ****
  // helpers
  // ****
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic step(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    tck <= 1'b0;
    repeat (2) @(posedge core_clk);
    o = tdo;
    tck <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : step
  task automatic sh(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] q);
    logic o;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      q[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    repeat (2) @(posedge core_clk);
  endtask : sh
  task automatic frame(input int n);
    int k;
    k = 0;
    run <= 1'b1;
    while (nb != 6'(n) && k < 200) begin
      @(posedge core_clk);
      k++;
    end
    check("frame", 32'(nb), 32'(n));
    run <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : frame
  task automatic tally_and_finish;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    repeat (47) @(posedge core_clk);
    check("rst_drive", 32'(rst_oe), 32'h1);
    check("data_oe", 32'(dout_oe), 32'h0);
    repeat (6) @(posedge core_clk);
    check("rst_drive", 32'(rst_oe), 32'h0);
  endtask : t_reset
  task automatic t_jtag;
    logic o;
    step(1'b0, 1'b0, o);
    sh(1'b1, 8, {24'h000000, `SCPR_OP_IDCODE}, v);
    check("ir_capture", {24'h000000, v[7:0]}, {24'h000000, `SCPR_IR_CAPTURE});
    sh(1'b0, 32, 32'h0, v);
    check("idcode", v, ID_V);
    check("tdo_oe", 32'(tdo_oe), 32'h0);
    sh(1'b1, 8, {24'h000000, `SCPR_OP_ISP_ENTER}, v);
    check("isp", 32'(isp), 32'h1);
    check("data_oe", 32'(dout_oe), 32'h0);
    sh(1'b1, 8, {24'h000000, `SCPR_OP_ISP_WRITE}, v);
    sh(1'b0, 16, {16'h0000, PAT}, v);
    sh(1'b1, 8, {24'h000000, `SCPR_OP_ISP_LEAVE}, v);
    check("data_oe", 32'(dout_oe), 32'h1);
  endtask : t_jtag
  task automatic t_read;
    check("casc", 32'(casc), 32'h1);
    frame(17);
    check("bits", {16'h0000, got[15:0]}, {16'h0000, PAT});
    check("casc", 32'(casc), 32'h0);
    check("next_sel", 32'(nxt), 32'h1);
    hold_low <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("casc", 32'(casc), 32'h1);
    check("data_oe", 32'(dout_oe), 32'h0);
    hold_low <= 1'b0;
    ce_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("data_oe", 32'(dout_oe), 32'h0);
    ce_n <= 1'b0;
    sel <= 1'b0;
    frame(3);
    check("no_count", {29'h0, got[2:0]}, {29'h0, {3{PAT[0]}}});
    sel <= 1'b1;
    frame(2);
    check("restart", {30'h0, got[1:0]}, {30'h0, PAT[1:0]});
  endtask : t_read
  initial begin
    {srst, tms} = 2'b11;
    {sel, ce_n, tck, tdi, run, hold_low} = 6'b100000;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_jtag();
    t_read();
    sh(1'b1, 8, {24'h000000, `SCPR_OP_LOAD_TRIG}, v);
    repeat (30) @(posedge core_clk);
    check("pulse_len", 32'(last_len), 32'(`SCPR_CFG_PULSE_CYC));
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    tally_and_finish();
  end
endmodule : scpr_top_test
